// [hdl/spr_receiver.sv]
// Biphase two-channel audio receiver with Wishbone register slave
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps

module spr_receiver #(
	parameter int ADR_W = 18,
	parameter int DIV_W = 8
) (
	// Clock, reset, enable
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	// Wishbone classic slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// Serial line and interrupt
	input  wire logic              spdif_rx_i,
	output logic                   irq_o
);
	import spr_pkg::*;

	// ****************************************************************
	// Run classification
	// ****************************************************************
	function automatic spr_run_t spr_class(input logic [3:0] len);
		spr_run_t c;
		c = RUN_BAD;
		if (len == 4'h0)
			c = RUN_BAD;
		else if (len <= RUN_SHORT_MAX)
			c = RUN_S;
		else if (len <= RUN_LONG_MAX)
			c = RUN_L;
		else if (len <= RUN_EXTRA_MAX)
			c = RUN_E;
		return c;
	endfunction : spr_class

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic                  en_r;
	logic                  ie_r;
	logic [15:0]           div_r;
	logic [SAMPLE_W-1:0]   ldat_r;
	logic [SAMPLE_W-1:0]   rdat_r;
	logic [15:0]           stat_r;
	logic [15:0]           stat_nxt;
	logic                  ack_r;
	logic [31:0]           dat_r;

	logic [DIV_W:0]        acc_r;
	logic [DIV_W:0]        acc_nxt;
	logic                  samp_r;
	logic [3:0]            run_r;
	spr_state_t            state_r;
	spr_state_t            state_nxt;
	logic [1:0]            pidx_r;
	logic [1:0]            pidx_nxt;
	spr_pre_t              kind_r;
	spr_pre_t              kind_nxt;
	logic                  half_r;
	logic                  half_nxt;
	logic [4:0]            bcnt_r;
	logic [4:0]            bcnt_nxt;
	logic [SUBFRAME_BITS-1:0] shift_r;
	logic [SUBFRAME_BITS-1:0] shift_nxt;
	logic                  right_r;
	logic                  right_nxt;
	logic                  last_xz_r;
	logic                  last_xz_nxt;
	logic                  seen_r;
	logic                  seen_nxt;
	logic                  have_z_r;
	logic                  have_z_nxt;
	logic [7:0]            fcnt_r;
	logic [7:0]            fcnt_nxt;
	logic [SAMPLE_W-1:0]   lsh_r;
	logic [2:0]            lvuc_r;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	wire logic [15:0] idx       = wb_adr_i[ADR_W-1:2];
	wire logic        access    = wb_cyc_i & wb_stb_i & ~ack_r;
	wire logic        wr        = access & wb_we_i;
	wire logic        rd        = access & ~wb_we_i;
	wire logic [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire logic [15:0] wdat      = wb_dat_i[15:0] & lane_mask;
	wire logic        wr_ctl    = wr & (idx == IDX_CONTROL);
	wire logic        wr_div    = wr & (idx == IDX_CLOCK_DIV);
	wire logic        wr_stat   = wr & (idx == IDX_STATUS);
	wire logic        rd_lhigh  = rd & (idx == IDX_LEFT_HIGH);
	wire logic [15:0] div_wr    = (div_r & ~lane_mask) | wdat;

	wire logic [15:0] ctl_word  = {12'h000, en_r, 1'b0, ie_r, 1'b0};
	wire logic [15:0] cnt_word  = {8'h00, fcnt_r};
	wire logic [15:0] lhi_word  = ldat_r[SAMPLE_W-1:SAMPLE_W-HIGH_W];
	wire logic [15:0] rhi_word  = rdat_r[SAMPLE_W-1:SAMPLE_W-HIGH_W];
	wire logic [15:0] llo_word  = {8'h00, ldat_r[SAMPLE_W-HIGH_W-1:0]};
	wire logic [15:0] rlo_word  = {8'h00, rdat_r[SAMPLE_W-HIGH_W-1:0]};
	wire logic [15:0] rd_word   =
		(idx == IDX_CONTROL)    ? ctl_word :
		(idx == IDX_CLOCK_DIV)  ? div_r    :
		(idx == IDX_LEFT_LOW)   ? llo_word :
		(idx == IDX_LEFT_HIGH)  ? lhi_word :
		(idx == IDX_RIGHT_LOW)  ? rlo_word :
		(idx == IDX_RIGHT_HIGH) ? rhi_word :
		(idx == IDX_STATUS)     ? stat_r   :
		(idx == IDX_COUNTERS)   ? cnt_word : REG_RESET;

	// ****************************************************************
	// Oversampling tick
	// ****************************************************************
	// divider steps sampling clock
	wire logic [DIV_W:0] div_ext = {1'b0, div_r[DIV_W-1:0]};
	wire logic [DIV_W:0] acc_add = acc_r + OVERSAMPLE[DIV_W:0];
	wire logic           tick    = en_r & (acc_add >= div_ext);
	assign acc_nxt = tick ? acc_add - div_ext : acc_add;

	// ****************************************************************
	// Run length measurement
	// ****************************************************************
	// sync by fractional divider
	wire logic     edge_seen = tick & (spdif_rx_i != samp_r);
	wire spr_run_t rcls      = spr_class(run_r);
	wire logic [3:0] run_inc = (run_r == 4'hf) ? run_r : run_r + 4'h1;

	// ****************************************************************
	// Decoder next state
	// ****************************************************************
	logic       bit_ok;
	logic       bit_val;
	logic       pre_done;
	logic       ev_bip;
	logic       ev_sf;
	logic       ev_fe;
	logic       ev_be;

	always_comb begin
		state_nxt   = state_r;
		pidx_nxt    = pidx_r;
		kind_nxt    = kind_r;
		half_nxt    = half_r;
		bcnt_nxt    = bcnt_r;
		right_nxt   = right_r;
		last_xz_nxt = last_xz_r;
		seen_nxt    = seen_r;
		have_z_nxt  = have_z_r;
		fcnt_nxt    = fcnt_r;
		bit_ok      = 1'b0;
		bit_val     = 1'b0;
		pre_done    = 1'b0;
		ev_bip      = 1'b0;
		ev_sf       = 1'b0;
		ev_fe       = 1'b0;
		ev_be       = 1'b0;
		if (edge_seen) begin
			case (state_r)
				ST_HUNT: begin
					if (rcls == RUN_E) begin
						state_nxt = ST_PRE;
						pidx_nxt  = 2'h1;
					end
				end
				ST_PRE: begin
					pidx_nxt = pidx_r + 2'h1;
					if (pidx_r == 2'h1) begin
						if (rcls == RUN_E)
							kind_nxt = PRE_X;
						else if (rcls == RUN_L)
							kind_nxt = PRE_Y;
						else if (rcls == RUN_S)
							kind_nxt = PRE_Z;
						else
							ev_bip = 1'b1;
					end else if (pidx_r == 2'h2) begin
						ev_bip = (rcls != RUN_S);
					end else begin
						case (kind_r)
							PRE_X:   ev_bip = (rcls != RUN_S);
							PRE_Y:   ev_bip = (rcls != RUN_L);
							PRE_Z:   ev_bip = (rcls != RUN_E);
							default: ev_bip = 1'b1;
						endcase
						pre_done = ~ev_bip;
					end
					if (ev_bip)
						state_nxt = ST_HUNT;
				end
				ST_DATA: begin
					case (rcls)
						RUN_S: begin
							half_nxt = ~half_r;
							bit_ok   = half_r;
							bit_val  = 1'b1;
						end
						RUN_L: begin
							ev_bip   = half_r;
							bit_ok   = ~half_r;
						end
						RUN_E: begin
							ev_sf     = (bcnt_r != SUBFRAME_BITS[4:0]);
							ev_bip    = half_r;
							state_nxt = ST_PRE;
							pidx_nxt  = 2'h1;
						end
						default: ev_bip = 1'b1;
					endcase
					if (ev_bip)
						state_nxt = ST_HUNT;
					if (bit_ok && bcnt_r != 5'h1f)
						bcnt_nxt = bcnt_r + 5'h1;
				end
				default: state_nxt = ST_HUNT;
			endcase
		end
		if (pre_done) begin
			state_nxt = ST_DATA;
			half_nxt  = 1'b0;
			bcnt_nxt  = 5'h00;
			seen_nxt  = 1'b1;
			if (kind_r == PRE_Y) begin
				ev_fe       = seen_r & ~last_xz_r;
				right_nxt   = 1'b1;
				last_xz_nxt = 1'b0;
			end else begin
				ev_fe       = seen_r & last_xz_r;
				right_nxt   = 1'b0;
				last_xz_nxt = 1'b1;
			end
			if (kind_r == PRE_Z) begin
				ev_be      = have_z_r & (fcnt_r != LAST_FRAME);
				have_z_nxt = 1'b1;
				fcnt_nxt   = 8'h00;
			end else if (kind_r == PRE_X) begin
				ev_be    = have_z_r & (fcnt_r == LAST_FRAME);
				fcnt_nxt = (fcnt_r == LAST_FRAME) ? 8'h00 : fcnt_r + 8'h01;
			end
		end
	end

	// ****************************************************************
	// Subframe completion
	// ****************************************************************
	assign shift_nxt = bit_ok ? {bit_val, shift_r[SUBFRAME_BITS-1:1]}
	                          : shift_r;
	wire logic sub_done = bit_ok & (bcnt_r == SUBFRAME_BITS[4:0] - 5'h1);
	wire logic [SAMPLE_W-1:0] sample = shift_nxt[SAMPLE_W-1:0];
	// V arrives first and lands in the top bit of the field
	wire logic [2:0]  vuc      = {shift_nxt[SAMPLE_W],
	                              shift_nxt[SAMPLE_W+1],
	                              shift_nxt[SAMPLE_W+2]};
	wire logic        par_bad  = ^shift_nxt;
	wire logic        ev_lp    = sub_done & ~right_r & par_bad;
	wire logic        ev_rp    = sub_done & right_r & par_bad;
	wire logic        ev_frame = sub_done & right_r;
	wire logic        frv      = stat_r[ST_FRCV_BIT];
	wire logic        ev_miss  = ev_frame & frv;

	// ****************************************************************
	// Status next value
	// ****************************************************************
	wire logic [15:0] stat_clr = wr_stat ? (wdat & STICKY_MASK) : 16'h0000;
	wire logic [15:0] stat_set =
		(16'(ev_miss) << ST_MISS_BIT) | (16'(ev_be) << ST_BERR_BIT) |
		(16'(ev_fe) << ST_FERR_BIT) | (16'(ev_sf) << ST_SFERR_BIT) |
		(16'(ev_bip) << ST_BIPH_BIT) | (16'(ev_rp) << ST_RIGHT_PARITY_FAIL_BIT) |
		(16'(ev_lp) << ST_LEFT_PARITY_FAIL_BIT);

	always_comb begin
		stat_nxt = ((stat_r & ~stat_clr) | stat_set) & STICKY_MASK;
		// set on frame, cleared by left high read
		stat_nxt[ST_FRCV_BIT] = ev_frame | (frv & ~rd_lhigh);
		stat_nxt[ST_RVUC_LSB+:3] = ev_frame ? vuc
		                                    : stat_r[ST_RVUC_LSB+:3];
		stat_nxt[ST_LVUC_LSB+:3] = ev_frame ? lvuc_r
		                                    : stat_r[ST_LVUC_LSB+:3];
	end

	// ****************************************************************
	// Register file
	// ****************************************************************
	// reset state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_r   <= 1'b0;
			ie_r   <= 1'b0;
			div_r  <= REG_RESET;
			stat_r <= REG_RESET;
			ack_r  <= 1'b0;
			dat_r  <= 32'h0000_0000;
		end else if (ce_i) begin
			if (wr_ctl && wb_sel_i[0]) begin
				en_r <= wb_dat_i[CTL_ENABLE_BIT];
				ie_r <= wb_dat_i[CTL_IRQ_EN_BIT];
			end
			if (wr_div)
				div_r <= div_wr;
			stat_r <= stat_nxt;
			ack_r  <= access;
			if (rd)
				dat_r <= {16'h0000, rd_word};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ldat_r <= {SAMPLE_W{1'b0}};
			rdat_r <= {SAMPLE_W{1'b0}};
			lsh_r  <= {SAMPLE_W{1'b0}};
			lvuc_r <= 3'h0;
		end else if (ce_i) begin
			if (sub_done && !right_r) begin
				lsh_r  <= sample;
				lvuc_r <= vuc;
			end
			if (ev_frame) begin
				ldat_r <= lsh_r;
				rdat_r <= sample;
			end
		end
	end

	// ****************************************************************
	// Decoder state, held in reset while disabled
	// ****************************************************************
	// enable low resets decoder
	wire logic dec_rst = rst_i | ~en_r;

	always_ff @(posedge clk_i) begin
		if (dec_rst) begin
			acc_r <= {(DIV_W+1){1'b0}};
			samp_r <= 1'b0;
			run_r  <= 4'h1;
		end else if (ce_i) begin
			acc_r <= acc_nxt;
			if (tick) begin
				samp_r <= spdif_rx_i;
				run_r  <= edge_seen ? 4'h1 : run_inc;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (dec_rst) begin
			state_r   <= ST_HUNT;
			pidx_r    <= 2'h0;
			kind_r    <= PRE_X;
			half_r    <= 1'b0;
			bcnt_r    <= 5'h00;
			shift_r   <= {SUBFRAME_BITS{1'b0}};
			right_r   <= 1'b0;
			last_xz_r <= 1'b0;
			seen_r    <= 1'b0;
			have_z_r  <= 1'b0;
			fcnt_r    <= 8'h00;
		end else if (ce_i) begin
			state_r   <= state_nxt;
			pidx_r    <= pidx_nxt;
			kind_r    <= kind_nxt;
			half_r    <= half_nxt;
			bcnt_r    <= bcnt_nxt;
			shift_r   <= shift_nxt;
			right_r   <= right_nxt;
			last_xz_r <= last_xz_nxt;
			seen_r    <= seen_nxt;
			have_z_r  <= have_z_nxt;
			fcnt_r    <= fcnt_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign irq_o    = ie_r & en_r & frv;

endmodule : spr_receiver

// [include/spr_pkg.sv]
// Shared constants and types for the biphase audio receiver
package spr_pkg;

	// ****************************************************************
	// Register indices (byte address is four times the index)
	// ****************************************************************
	localparam logic [15:0] IDX_CONTROL     = 16'hfd00;
	localparam logic [15:0] IDX_CLOCK_DIV   = 16'hfd01;
	localparam logic [15:0] IDX_LEFT_LOW    = 16'hfd02;
	localparam logic [15:0] IDX_LEFT_HIGH   = 16'hfd03;
	localparam logic [15:0] IDX_RIGHT_LOW   = 16'hfd04;
	localparam logic [15:0] IDX_RIGHT_HIGH  = 16'hfd05;
	localparam logic [15:0] IDX_STATUS      = 16'hfd06;
	localparam logic [15:0] IDX_COUNTERS    = 16'hfd07;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int          CTL_ENABLE_BIT  = 3;
	localparam int          CTL_IRQ_EN_BIT  = 1;
	localparam int          ST_FRCV_BIT     = 14;
	localparam int          ST_MISS_BIT     = 12;
	localparam int          ST_BERR_BIT     = 11;
	localparam int          ST_FERR_BIT     = 10;
	localparam int          ST_SFERR_BIT    = 9;
	localparam int          ST_BIPH_BIT     = 8;
	localparam int          ST_RIGHT_PARITY_FAIL_BIT    = 7;
	localparam int          ST_LEFT_PARITY_FAIL_BIT    = 6;
	localparam int          ST_RVUC_LSB     = 3;
	localparam int          ST_LVUC_LSB     = 0;
	localparam logic [15:0] REG_RESET       = 16'h0000;
	localparam logic [15:0] STICKY_MASK     = 16'h1fc0;

	// ****************************************************************
	// Line format
	// ****************************************************************
	localparam int          SAMPLE_W        = 24;
	localparam int          HIGH_W          = 16;
	localparam int          SUBFRAME_BITS   = 28;
	localparam logic [7:0]  LAST_FRAME      = 8'hbf;
	localparam logic [8:0]  OVERSAMPLE      = 9'h004;

	// Run lengths in oversampling ticks: half slot, slot, 1.5 slots
	localparam logic [3:0]  RUN_SHORT_MAX   = 4'h3;
	localparam logic [3:0]  RUN_LONG_MAX    = 4'h5;
	localparam logic [3:0]  RUN_EXTRA_MAX   = 4'h7;

	typedef enum logic [1:0] {
		RUN_S   = 2'h0,
		RUN_L   = 2'h1,
		RUN_E   = 2'h2,
		RUN_BAD = 2'h3
	} spr_run_t;

	typedef enum logic [1:0] {
		PRE_X = 2'h0,
		PRE_Y = 2'h1,
		PRE_Z = 2'h2
	} spr_pre_t;

	typedef enum logic [2:0] {
		ST_HUNT = 3'b001,
		ST_PRE  = 3'b010,
		ST_DATA = 3'b100
	} spr_state_t;

endpackage : spr_pkg

// [test/spr_receiver_properties.sv]
// Bus, interrupt and register read properties of the audio receiver
`timescale 1ns/1ps

module spr_receiver_properties #(
	parameter int ADR_W = 18
) (
	// Clock and reset
	input wire logic             clk_i,
	input wire logic             rst_i,
	input wire logic             ce_i,
	// Register bus
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0]       wb_sel_i,
	input wire logic [31:0]      wb_dat_i,
	input wire logic [31:0]      wb_dat_o,
	input wire logic             wb_ack_o,
	// Line and interrupt
	input wire logic             spdif_rx_i,
	input wire logic             irq_o
);
	import spr_pkg::*;

	wire        take   = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
	wire        rd_ack = wb_ack_o && !wb_we_i;
	wire [15:0] idx    = wb_adr_i[ADR_W-1:2];
	wire        ctl_wr = take && wb_we_i && wb_sel_i[0] && idx == IDX_CONTROL;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	ack_follows_a: assert property (take |=> wb_ack_o)
		else $error("request not answered next cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(take))
		else $error("ack without request");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	ctl_fields_a: assert property (
		rd_ack && idx == IDX_CONTROL |-> (wb_dat_o[15:0] & 16'hfff5) == 16'h0000)
		else $error("control reads unused bits");
	frcv_clear_a: assert property (
		take && !wb_we_i && idx == IDX_LEFT_HIGH |=> !irq_o)
		else $error("left high read left interrupt up");
	irq_mask_a: assert property (
		ctl_wr && !(wb_dat_i[1] && wb_dat_i[3]) |=> !irq_o [*2])
		else $error("interrupt up while masked");
	irq_hold_a: assert property (
		irq_o && !ctl_wr && !(take && !wb_we_i && idx == IDX_LEFT_HIGH)
		|=> irq_o)
		else $error("interrupt dropped without cause");
	cnt_range_a: assert property (
		rd_ack && idx == IDX_COUNTERS
		|-> wb_dat_o[15:8] == 8'h00 && wb_dat_o[7:0] <= LAST_FRAME)
		else $error("frame number out of range");
	unmapped_zero_a: assert property (
		rd_ack && (idx < IDX_CONTROL || idx > IDX_COUNTERS)
		|-> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");

	cover property (irq_o ##1 !irq_o);
	cover property (rd_ack && idx == IDX_STATUS && wb_dat_o[ST_MISS_BIT]);
	cover property (rd_ack && idx == IDX_STATUS && wb_dat_o[ST_BERR_BIT]);

endmodule : spr_receiver_properties

bind spr_receiver spr_receiver_properties #(.ADR_W(ADR_W)) prop_u (
	.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .spdif_rx_i, .irq_o);

// [test/spr_tx_model.sv]
// Behavioural biphase line transmitter feeding the receiver
`timescale 1ns/1ps

module spr_tx_model (
	// Clock and half slot length in clocks
	input  wire logic        clk_i,
	input  wire logic [7:0]  half_i,
	// Frame content
	input  wire logic [23:0] left_i,
	input  wire logic [23:0] right_i,
	input  wire logic [2:0]  lvuc_i,
	input  wire logic [2:0]  rvuc_i,
	input  wire logic [1:0]  bad_par_i,
	input  wire logic [7:0]  zper_i,
	// Line and progress
	output logic             line_o,
	output logic [7:0]       fidx_o,
	output int               frames_o
);
	logic [7:0] f;

	// Transition, then hold for h half slots
	task automatic run(input logic [3:0] h);
		line_o <= ~line_o;
		repeat (h * half_i) @(posedge clk_i);
	endtask : run

	task automatic sub(input logic [15:0] pre, input logic [26:0] w,
		input logic bp);
		logic [27:0] s;
		s = {^w ^ bp, w};
		for (int i = 3; i >= 0; i--) run(pre[i*4 +: 4]);
		for (int i = 0; i < 28; i++) begin
			if (s[i]) begin
				run(4'h1);
				run(4'h1);
			end else begin
				run(4'h2);
			end
		end
	endtask : sub

	// Z opens block, X then Y
	initial begin
		line_o = 1'b0;
		fidx_o = 8'h00;
		frames_o = 0;
		f = 8'h00;
		@(posedge clk_i);
		forever begin
			sub((f == 8'h00) ? 16'h3113 : 16'h3311,
				{lvuc_i[0], lvuc_i[1], lvuc_i[2], left_i}, bad_par_i[0]);
			sub(16'h3212, {rvuc_i[0], rvuc_i[1], rvuc_i[2], right_i},
				bad_par_i[1]);
			fidx_o <= f;
			frames_o <= frames_o + 1;
			f = (f + 8'h01 >= zper_i) ? 8'h00 : f + 8'h01;
		end
	end

endmodule : spr_tx_model

// [test/testbench.sv]
// Self-checking bench for the biphase audio receiver
`timescale 1ns/1ps

module testbench;
	import spr_pkg::*;

	logic        clk_i, rst_i, cyc, stb, we, ack, irq, line, ce, mute;
	logic [17:0] adr;
	logic [31:0] dat, rdat;
	logic [23:0] left, right;
	logic [2:0]  lvuc, rvuc;
	logic [1:0]  bad_par;
	logic [7:0]  zper, fidx, half;
	logic [15:0] q;
	int          frames;
	int          miscompares = 0;
	int          checks = 0;
	logic [15:0] divs [2] = '{16'h0008, 16'h0004};
	logic [32:0] rows [16] = '{
		33'h0_fd00_0000, 33'h0_fd01_0000, 33'h0_fd02_0000, 33'h0_fd03_0000,
		33'h0_fd04_0000, 33'h0_fd05_0000, 33'h0_fd06_0000, 33'h0_fd07_0000,
		33'h1_fd01_0008, 33'h0_fd01_0008, 33'h1_fd03_ffff, 33'h0_fd03_0000,
		33'h1_fd0a_1234, 33'h0_fd0a_0000, 33'h1_fd00_ffff, 33'h0_fd00_000a};

	spr_receiver #(.ADR_W(18), .DIV_W(8)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.spdif_rx_i(line & ~mute), .irq_o(irq));

	spr_tx_model tx_u (
		.clk_i(clk_i), .half_i(half), .left_i(left), .right_i(right),
		.lvuc_i(lvuc), .rvuc_i(rvuc), .bad_par_i(bad_par), .zper_i(zper),
		.line_o(line), .fidx_o(fidx), .frames_o(frames));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic complete_run;
		if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Classic cycle: hold until ack is sampled, then release
	task automatic bus(input logic w, input logic [15:0] i,
		input logic [15:0] d);
		int n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		dat <= {16'h0000, d};
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 64) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 64) miscompares++;
		q = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus

	task automatic rd(input logic [15:0] i, input logic [15:0] e);
		bus(1'b0, i, 16'h0000);
		chk(q, e);
	endtask : rd

	task automatic wait_frame;
		int f;
		f = frames;
		for (int k = 0; k < 4000 && frames == f; k++) @(posedge clk_i);
		if (frames == f) miscompares++;
		repeat (8) @(posedge clk_i);
	endtask : wait_frame

	task automatic settle;
		repeat (3) wait_frame;
		bus(1'b0, IDX_LEFT_HIGH, 16'h0000);
		bus(1'b1, IDX_STATUS, STICKY_MASK);
	endtask : settle

	initial begin
		repeat (40000) @(posedge clk_i);
		miscompares++;
		complete_run;
	end

	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = '0;
		dat = '0;
		rst_i = 1'b1;
		ce = 1'b1;
		mute = 1'b0;
		left = 24'h123456;
		right = 24'hfedcba;
		lvuc = 3'b110;
		rvuc = 3'b001;
		bad_par = 2'b00;
		zper = 8'hc0;
		half = 8'h04;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[k]) begin
			if (rows[k][32]) bus(1'b1, rows[k][31:16], rows[k][15:0]);
			else rd(rows[k][31:16], rows[k][15:0]);
		end
		// Words and flags at two divider settings
		foreach (divs[k]) begin
			bus(1'b1, IDX_CLOCK_DIV, divs[k]);
			half <= divs[k][8:1];
			left <= left ^ 24'hf0f0f0;
			settle;
			wait_frame;
			rd(IDX_STATUS, {10'h100, rvuc, lvuc});
			chk({15'h0000, irq}, 16'h0001);
			rd(IDX_LEFT_LOW, {8'h00, left[7:0]});
			rd(IDX_LEFT_HIGH, left[23:8]);
			rd(IDX_RIGHT_LOW, {8'h00, right[7:0]});
			rd(IDX_RIGHT_HIGH, right[23:8]);
			rd(IDX_STATUS, {10'h000, rvuc, lvuc});
		end
		// Missed read, masking and sticky clear
		wait_frame;
		wait_frame;
		rd(IDX_STATUS, {10'h140, rvuc, lvuc});
		bus(1'b1, IDX_CONTROL, 16'h0008);
		chk({15'h0000, irq}, 16'h0000);
		bus(1'b1, IDX_CONTROL, 16'h000a);
		chk({15'h0000, irq}, 16'h0001);
		rd(IDX_LEFT_HIGH, left[23:8]);
		rd(IDX_STATUS, {10'h040, rvuc, lvuc});
		bus(1'b1, IDX_STATUS, 16'h1000);
		rd(IDX_STATUS, {10'h000, rvuc, lvuc});
		// Parity fault on each channel alone
		for (int k = 1; k < 3; k++) begin
			bad_par <= k[1:0];
			repeat (2) wait_frame;
			bad_par <= 2'b00;
			wait_frame;
			bus(1'b0, IDX_STATUS, 16'h0000);
			chk(q & 16'h0fc0, 16'h0020 << k);
			settle;
		end
		// Short block spacing
		zper <= 8'h04;
		repeat (6) wait_frame;
		rd(IDX_COUNTERS, {8'h00, fidx});
		bus(1'b0, IDX_STATUS, 16'h0000);
		chk(q & 16'h0fc0, 16'h0800);
		zper <= 8'hc0;
		// Line held low across a preamble: coding and frame errors
		settle;
		wait_frame;
		mute <= 1'b1;
		repeat (96) @(posedge clk_i);
		mute <= 1'b0;
		repeat (2) wait_frame;
		bus(1'b0, IDX_STATUS, 16'h0000);
		chk(q & 16'h0500, 16'h0500);
		// Disable keeps words, clears frame number
		bus(1'b1, IDX_CONTROL, 16'h0002);
		rd(IDX_COUNTERS, 16'h0000);
		rd(IDX_LEFT_HIGH, left[23:8]);
		chk({15'h0000, irq}, 16'h0000);
		// Clock enable low holds the bus answer back
		ce <= 1'b0;
		fork
			bus(1'b0, IDX_CONTROL, 16'h0000);
			begin
				repeat (6) @(posedge clk_i);
				chk({15'h0000, ack}, 16'h0000);
				ce <= 1'b1;
			end
		join
		chk(q, 16'h0002);
		// Reset in mid-run
		bus(1'b1, IDX_CONTROL, 16'h000a);
		wait_frame;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk({15'h0000, irq}, 16'h0000);
		for (int k = 0; k < 8; k++) begin
			rd(IDX_CONTROL + k[15:0], 16'h0000);
		end
		complete_run;
	end

endmodule : testbench
